// ### hdl/cpt_pkg.sv
package cpt_pkg;
   localparam int          ADDR_W       = 18;
   localparam int          DATA_W       = 32;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_MODE     = 16'hffc0;
   localparam logic [15:0] IDX_CLKOUT   = 16'hffc1;
   localparam logic [15:0] IDX_RUN0     = 16'hffc2;
   localparam logic [15:0] IDX_RUN1     = 16'hffc3;
   localparam logic [15:0] IDX_RLD0L    = 16'hffc4;
   localparam logic [15:0] IDX_RLD0H    = 16'hffc5;
   localparam logic [15:0] IDX_RLD1L    = 16'hffc6;
   localparam logic [15:0] IDX_RLD1H    = 16'hffc7;
   localparam logic [15:0] IDX_CNT0L    = 16'hffc8;
   localparam logic [15:0] IDX_CNT0H    = 16'hffc9;
   localparam logic [15:0] IDX_CNT1L    = 16'hffca;
   localparam logic [15:0] IDX_CNT1H    = 16'hffcb;
   localparam logic [15:0] IDX_MASK     = 16'hffe2;
   localparam logic [15:0] IDX_FLAG     = 16'hfff2;
   // Field positions
   localparam int          MODE_CHAIN   = 3;
   localparam int          MODE_EVENT   = 2;
   localparam int          MODE_FILT    = 1;
   localparam int          MODE_POL     = 0;
   localparam int          CO_CHAN      = 3;
   localparam int          CO_TOG_EN    = 2;
   localparam int          CO_SRC1      = 1;
   localparam int          CO_SRC0      = 0;
   localparam int          RUN_RATIO    = 2;
   localparam int          RUN_PRESET   = 1;
   localparam int          RUN_RUN      = 0;
   localparam int          IRQ_HI       = 1;
   localparam int          IRQ_LO       = 0;
   // Reset values
   localparam logic [3:0]  NIB_RST      = 4'h0;
   localparam logic [15:0] CNT_RST      = 16'h0000;
   localparam logic [1:0]  BIT2_RST     = 2'h0;
   localparam logic        PORT_IDLE    = 1'b1;
   localparam logic        EV_RST_LVL   = 1'b1;
   // Stable filter ticks before an input level is accepted
   localparam logic [1:0]  FILTER_TICKS = 2'h2;
   typedef enum logic [1:0] {RATIO_1, RATIO_4, RATIO_32, RATIO_256} cpt_ratio_e;
endpackage

// ### hdl/cpt_tick_if.sv
interface cpt_tick_if;
   logic       lowOsc;
   logic       highOsc;
   logic       srcSel;
   logic       run;
   logic [1:0] ratio;
   logic       preTick;
   logic       evIn;
   logic       filtTick;
   logic       filtEn;
   logic       pol;
   logic       evEn;
   logic       evTick;
   modport presc (input lowOsc, highOsc, srcSel, run, ratio, output preTick);
   modport evin (input evIn, filtTick, filtEn, pol, evEn, output evTick);
   modport core (output lowOsc, highOsc, srcSel, run, ratio, evIn, filtTick, filtEn, pol,
                 evEn, input preTick, evTick);
endinterface

// ### hdl/cpt_prescaler.sv
module cpt_prescaler (
   input wire logic   clk,
   input wire logic   rst,
   cpt_tick_if.presc  t
);
   logic [7:0] cnt_q;
   logic       tick_q;
   logic       src;
   logic [7:0] lim;

   function automatic logic [7:0] ratioLimit(input logic [1:0] r);
      unique case (cpt_pkg::cpt_ratio_e'(r))
         cpt_pkg::RATIO_1:   ratioLimit = 8'h00;
         cpt_pkg::RATIO_4:   ratioLimit = 8'h03;
         cpt_pkg::RATIO_32:  ratioLimit = 8'h1f;
         cpt_pkg::RATIO_256: ratioLimit = 8'hff;
      endcase
   endfunction

   assign src = t.srcSel ? t.highOsc : t.lowOsc;
   assign lim = ratioLimit(t.ratio);

   always_ff @(posedge clk) begin
      if (rst || !t.run) begin
         cnt_q <= 8'h00;
      end else if (src) begin
         cnt_q <= (cnt_q >= lim) ? 8'h00 : cnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      tick_q <= !rst && t.run && src && (cnt_q >= lim);
   end

   assign t.preTick = tick_q;
endmodule

// ### hdl/cpt_event_in.sv
module cpt_event_in (
   input wire logic  clk,
   input wire logic  rst,
   cpt_tick_if.evin  t
);
   logic       acc_q;
   logic       prev_q;
   logic [1:0] fcnt_q;
   logic       tick_q;

   // Filtered mode: level must hold over the filter ticks before it is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_q  <= cpt_pkg::EV_RST_LVL;
         fcnt_q <= 2'h0;
      end else if (!t.filtEn) begin
         acc_q  <= t.evIn;
         fcnt_q <= 2'h0;
      end else if (t.evIn == acc_q) begin
         fcnt_q <= 2'h0;
      end else if (t.filtTick) begin
         if (fcnt_q == cpt_pkg::FILTER_TICKS - 2'h1) begin
            acc_q  <= t.evIn;
            fcnt_q <= 2'h0;
         end else begin
            fcnt_q <= fcnt_q + 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_q <= cpt_pkg::EV_RST_LVL;
         tick_q <= 1'b0;
      end else begin
         prev_q <= acc_q;
         tick_q <= t.evEn && (acc_q != prev_q) && (acc_q == t.pol);
      end
   end

   assign t.evTick = tick_q;
endmodule

// ### hdl/cpt_timer16.sv
// Functional notes
// - Timer 0 low, timer 1 high: 16-bit down counter
// - Underflow reloads counter, counting continues
// - Preset bit loads reload value immediately
// - Low nibble read holds higher nibbles
// - Source select: 0 slow, 1 fast oscillator
// - Ratio codes divide by 1, 4, 32, 256
// - Run bit feeds prescaler, output clocks counter
// - Event mode ignores source and ratio
// - Underflow sets high flag, requests interrupt
// - Mask gates request only, flag always set
// - Each underflow inverts the toggle output
// - Enable drives toggle on port bit 2, else high
// - Enable switching may glitch half cycle
// - Serial clock is toggle while running
// - Mode bit: 1 event counter, 0 timer
// - Filter bit enables noise rejection, event only
// - Reload in four read/write nibbles, reset zero
// - Live count in four read-only nibbles
// - Mask register bits 1 and 0, reset zero
// - Flag register two low bits, upper zero
//
// The APB interface to the registers was decided locally.
module cpt_timer16 (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [cpt_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [cpt_pkg::DATA_W-1:0]  pwdata,
   output logic      [cpt_pkg::DATA_W-1:0]  prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        lowOscTick,
   input  wire logic                        highOscTick,
   input  wire logic                        eventIn,
   input  wire logic                        filterTick,
   output logic                             irqReq,
   output logic                             outPortBit2,
   output logic                             serialClk
);
   logic [3:0]                   mode_q;
   logic [3:0]                   clkOut_q;
   logic [2:0]                   run0_q;
   logic [2:0]                   run1_q;
   logic [15:0]                  rld_q;
   logic [15:0]                  cnt_q;
   logic [11:0]                  hold_q;
   logic [1:0]                   mask_q;
   logic [1:0]                   flag_q;
   logic                         tog_q;
   logic                         port_q;
   logic                         ser_q;
   logic                         irq_q;
   logic [cpt_pkg::DATA_W-1:0]   prdata_q;
   logic                         pready_q;
   logic                         pslverr_q;
   logic [15:0]                  idx;
   logic                         setup;
   logic                         wr;
   logic                         rdSetup;
   logic                         presetW;
   logic                         running;
   logic                         cntTick;
   logic                         underflow;
   logic [1:0]                   flagClr;
   logic [3:0]                   rdVal;
   logic                         mapped;

   cpt_tick_if tk ();

   assign idx     = paddr[cpt_pkg::ADDR_W-1:2];
   assign setup   = psel && !penable;
   assign wr      = psel && penable && pready_q && pwrite && (paddr[1:0] == 2'h0);
   assign rdSetup = setup && !pwrite;
   assign running = run0_q[cpt_pkg::RUN_RUN];

   function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
      hit = (a == r);
   endfunction

   // Tick sources
   assign tk.lowOsc   = lowOscTick;
   assign tk.highOsc  = highOscTick;
   assign tk.srcSel   = clkOut_q[cpt_pkg::CO_SRC0];
   assign tk.run      = running && !mode_q[cpt_pkg::MODE_EVENT];
   // Ratio is stored in bits 2:1 since the preset bit is not kept
   assign tk.ratio    = run0_q[2:1];
   assign tk.evIn     = eventIn;
   assign tk.filtTick = filterTick;
   assign tk.filtEn   = mode_q[cpt_pkg::MODE_FILT] && mode_q[cpt_pkg::MODE_EVENT];
   assign tk.pol      = mode_q[cpt_pkg::MODE_POL];
   assign tk.evEn     = mode_q[cpt_pkg::MODE_EVENT];

   cpt_prescaler u_presc (
      .clk (clk),
      .rst (rst),
      .t   (tk)
   );

   cpt_event_in u_evin (
      .clk (clk),
      .rst (rst),
      .t   (tk)
   );

   // timer 0 run bit gates counting
   assign cntTick   = running && (mode_q[cpt_pkg::MODE_EVENT] ? tk.evTick : tk.preTick);
   assign presetW   = wr && hit(idx, cpt_pkg::IDX_RUN0) && pwdata[cpt_pkg::RUN_PRESET];
   assign underflow = cntTick && !presetW && (cnt_q == 16'h0000);
   assign flagClr   = (wr && hit(idx, cpt_pkg::IDX_FLAG)) ? pwdata[1:0] : 2'h0;

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= cpt_pkg::NIB_RST;
      end else if (wr && hit(idx, cpt_pkg::IDX_MODE)) begin
         mode_q <= pwdata[3:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         clkOut_q <= cpt_pkg::NIB_RST;
      end else if (wr && hit(idx, cpt_pkg::IDX_CLKOUT)) begin
         clkOut_q <= pwdata[3:0];
      end
   end

   // Preset bit is a strobe and is not stored
   always_ff @(posedge clk) begin
      if (rst) begin
         run0_q <= 3'h0;
         run1_q <= 3'h0;
      end else if (wr && hit(idx, cpt_pkg::IDX_RUN0)) begin
         run0_q <= {pwdata[3:2], pwdata[0]};
      end else if (wr && hit(idx, cpt_pkg::IDX_RUN1)) begin
         run1_q <= {pwdata[3:2], pwdata[0]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rld_q <= cpt_pkg::CNT_RST;
      end else if (wr) begin
         if (hit(idx, cpt_pkg::IDX_RLD0L)) rld_q[3:0]   <= pwdata[3:0];
         if (hit(idx, cpt_pkg::IDX_RLD0H)) rld_q[7:4]   <= pwdata[3:0];
         if (hit(idx, cpt_pkg::IDX_RLD1L)) rld_q[11:8]  <= pwdata[3:0];
         if (hit(idx, cpt_pkg::IDX_RLD1H)) rld_q[15:12] <= pwdata[3:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= cpt_pkg::CNT_RST;
      end else if (presetW) begin
         cnt_q <= rld_q;
      end else if (cntTick) begin
         cnt_q <= (cnt_q == 16'h0000) ? rld_q : cnt_q - 16'h0001;
      end
   end

   // hold upper nibbles on low read
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_q <= 12'h000;
      end else if (rdSetup && hit(idx, cpt_pkg::IDX_CNT0L)) begin
         hold_q <= cnt_q[15:4];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mask_q <= cpt_pkg::BIT2_RST;
      end else if (wr && hit(idx, cpt_pkg::IDX_MASK)) begin
         mask_q <= pwdata[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flag_q <= cpt_pkg::BIT2_RST;
      end else begin
         flag_q[cpt_pkg::IRQ_HI] <= (flag_q[cpt_pkg::IRQ_HI] && !flagClr[cpt_pkg::IRQ_HI])
                                    || underflow;
         flag_q[cpt_pkg::IRQ_LO] <= flag_q[cpt_pkg::IRQ_LO] && !flagClr[cpt_pkg::IRQ_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flag_q & mask_q);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tog_q <= 1'b0;
      end else if (underflow) begin
         tog_q <= !tog_q;
      end
   end

   // enable is registered with the toggle, so no hazard here
   always_ff @(posedge clk) begin
      if (rst) begin
         port_q <= cpt_pkg::PORT_IDLE;
      end else begin
         port_q <= clkOut_q[cpt_pkg::CO_TOG_EN] ? tog_q : cpt_pkg::PORT_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ser_q <= 1'b0;
      end else begin
         ser_q <= running ? tog_q : 1'b0;
      end
   end

   // Read decode
   // count readback: low nibble live, upper nibbles from the hold snapshot
   always_comb begin
      mapped = 1'b1;
      rdVal  = 4'h0;
      unique case (idx)
         cpt_pkg::IDX_MODE:   rdVal = mode_q;
         cpt_pkg::IDX_CLKOUT: rdVal = clkOut_q;
         cpt_pkg::IDX_RUN0:   rdVal = {run0_q[2:1], 1'b0, run0_q[0]};
         cpt_pkg::IDX_RUN1:   rdVal = {run1_q[2:1], 1'b0, run1_q[0]};
         cpt_pkg::IDX_RLD0L:  rdVal = rld_q[3:0];
         cpt_pkg::IDX_RLD0H:  rdVal = rld_q[7:4];
         cpt_pkg::IDX_RLD1L:  rdVal = rld_q[11:8];
         cpt_pkg::IDX_RLD1H:  rdVal = rld_q[15:12];
         cpt_pkg::IDX_CNT0L:  rdVal = cnt_q[3:0];
         cpt_pkg::IDX_CNT0H:  rdVal = hold_q[3:0];
         cpt_pkg::IDX_CNT1L:  rdVal = hold_q[7:4];
         cpt_pkg::IDX_CNT1H:  rdVal = hold_q[11:8];
         cpt_pkg::IDX_MASK:   rdVal = {2'h0, mask_q};
         cpt_pkg::IDX_FLAG:   rdVal = {2'h0, flag_q};
         default:             mapped = 1'b0;
      endcase
      if (paddr[1:0] != 2'h0) begin
         mapped = 1'b0;
      end
   end

   // APB answer: one wait-free access phase after every setup
   always_ff @(posedge clk) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup && !mapped;
         prdata_q  <= (rdSetup && mapped) ? {28'h0, rdVal} : '0;
      end
   end

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign irqReq      = irq_q;
   assign outPortBit2 = port_q;
   assign serialClk   = ser_q;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_reload;
      underflow |=> (cnt_q == $past(rld_q));
   endproperty
   a_reload: assert property (p_reload) else $error("counter not reloaded");

   property p_preset;
      presetW |=> (cnt_q == $past(rld_q));
   endproperty
   a_preset: assert property (p_preset) else $error("preset not loaded");

   property p_count;
      cntTick && !presetW && (cnt_q != 16'h0000) |=> (cnt_q == $past(cnt_q) - 16'h0001);
   endproperty
   a_count: assert property (p_count) else $error("bad decrement");

   property p_hold;
      rdSetup && hit(idx, cpt_pkg::IDX_CNT0L) |=> (hold_q == $past(cnt_q[15:4]));
   endproperty
   a_hold: assert property (p_hold) else $error("high nibbles not held");

   property p_flag;
      underflow |=> flag_q[cpt_pkg::IRQ_HI];
   endproperty
   a_flag: assert property (p_flag) else $error("flag lost");

   property p_mask;
      flag_q[cpt_pkg::IRQ_HI] && mask_q[cpt_pkg::IRQ_HI] |=> irqReq;
   endproperty
   a_mask: assert property (p_mask) else $error("request missing");

   property p_toggle;
      underflow |=> (tog_q != $past(tog_q));
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle not inverted");

   property p_port;
      !clkOut_q[cpt_pkg::CO_TOG_EN] ##1 !clkOut_q[cpt_pkg::CO_TOG_EN] |-> outPortBit2;
   endproperty
   a_port: assert property (p_port) else $error("port bit not idle high");

   property p_serial;
      running ##1 running && $stable(tog_q) |-> (serialClk == tog_q);
   endproperty
   a_serial: assert property (p_serial) else $error("serial clock wrong");

   property p_stop;
      !running && !presetW |=> $stable(cnt_q);
   endproperty
   a_stop: assert property (p_stop) else $error("count moved while stopped");

   property p_event;
      mode_q[cpt_pkg::MODE_EVENT] && $past(mode_q[cpt_pkg::MODE_EVENT]) |-> !tk.preTick;
   endproperty
   a_event: assert property (p_event) else $error("prescaler active in event mode");

   property p_flagzero;
      pready && !pslverr && $past(hit(idx, cpt_pkg::IDX_FLAG)) |-> (prdata[3:2] == 2'h0);
   endproperty
   a_flagzero: assert property (p_flagzero) else $error("flag upper bits set");

   c_underflow: cover property (underflow ##[1:20] underflow);
   c_preset: cover property (presetW ##1 running);
   c_irq: cover property (irqReq ##1 !irqReq);
   c_serial: cover property (running && $rose(serialClk));
endmodule

// ### sim/cpt_timer16_tb.sv
module cpt_timer16_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk;
   logic        rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [17:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        lowOscTick;
   logic        highOscTick;
   logic        eventIn;
   logic        filterTick;
   logic        irqReq;
   logic        outPortBit2;
   logic        serialClk;
   logic [31:0] rd;
   logic        err;
   int          errors;
   int          comparisons;
   int          c;
   localparam logic [15:0] REGS [14] = '{cpt_pkg::IDX_MODE, cpt_pkg::IDX_CLKOUT,
      cpt_pkg::IDX_RUN0, cpt_pkg::IDX_RUN1, cpt_pkg::IDX_RLD0L, cpt_pkg::IDX_RLD0H,
      cpt_pkg::IDX_RLD1L, cpt_pkg::IDX_RLD1H, cpt_pkg::IDX_CNT0L, cpt_pkg::IDX_CNT0H,
      cpt_pkg::IDX_CNT1L, cpt_pkg::IDX_CNT1H, cpt_pkg::IDX_MASK, cpt_pkg::IDX_FLAG};
   localparam int RATIO [4] = '{1, 4, 32, 256};

   cpt_timer16 u_dut (
      .clk         (clk),
      .rst         (rst),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .lowOscTick  (lowOscTick),
      .highOscTick (highOscTick),
      .eventIn     (eventIn),
      .filterTick  (filterTick),
      .irqReq      (irqReq),
      .outPortBit2 (outPortBit2),
      .serialClk   (serialClk)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic stop_test();
      if (errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chkNib(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkBit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
         errors++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
   endtask

   task automatic rdChk(input logic [15:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chkNib(rd, exp);
   endtask

   task automatic setReload(input logic [15:0] v);
      wr(cpt_pkg::IDX_RLD0L, {28'h0, v[3:0]});
      wr(cpt_pkg::IDX_RLD0H, {28'h0, v[7:4]});
      wr(cpt_pkg::IDX_RLD1L, {28'h0, v[11:8]});
      wr(cpt_pkg::IDX_RLD1H, {28'h0, v[15:12]});
   endtask

   // Low nibble first so the upper nibbles come from one snapshot
   task automatic rdCount(input logic [15:0] v);
      rdChk(cpt_pkg::IDX_CNT0L, {28'h0, v[3:0]});
      rdChk(cpt_pkg::IDX_CNT0H, {28'h0, v[7:4]});
      rdChk(cpt_pkg::IDX_CNT1L, {28'h0, v[11:8]});
      rdChk(cpt_pkg::IDX_CNT1H, {28'h0, v[15:12]});
   endtask

   task automatic pulse(input int which, input int n);
      repeat (n) begin
         @(posedge clk);
         lowOscTick <= (which == 0);
         highOscTick <= (which == 1);
         filterTick <= (which == 2);
         @(posedge clk);
         lowOscTick <= 1'b0;
         highOscTick <= 1'b0;
         filterTick <= 1'b0;
      end
   endtask

   task automatic evSet(input logic v);
      @(posedge clk);
      eventIn <= v;
      idle(3);
   endtask

   task automatic doReset();
      @(posedge clk);
      rst <= 1'b1;
      idle(8);
      rst <= 1'b0;
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      lowOscTick = 1'b0;
      highOscTick = 1'b0;
      eventIn = 1'b1;
      filterTick = 1'b0;
      errors = 0;
      comparisons = 0;
      doReset();
      chkBit(outPortBit2, 1'b1);
      chkBit(serialClk, 1'b0);
      for (c = 0; c < 14; c++) begin
         rdChk(REGS[c], 32'h0);
      end
      apb(1'b0, 16'hffd0, 32'h0);
      chkBit(err, 1'b1);
      chkNib(rd, 32'h0);
      wr(cpt_pkg::IDX_CNT0L, 32'h5);
      rdChk(cpt_pkg::IDX_CNT0L, 32'h0);
      // Every ratio code, two counts each
      for (c = 0; c < 4; c++) begin
         doReset();
         setReload(16'h1234);
         rdChk(cpt_pkg::IDX_RLD1L, 32'h2);
         wr(cpt_pkg::IDX_RUN0, 32'h2);
         rdCount(16'h1234);
         wr(cpt_pkg::IDX_RUN0, (c << 2) | 1);
         pulse(0, 2 * RATIO[c]);
         idle(3);
         wr(cpt_pkg::IDX_RUN0, c << 2);
         rdCount(16'h1232);
      end
      doReset();
      setReload(16'h0010);
      wr(cpt_pkg::IDX_CLKOUT, 32'h1);
      wr(cpt_pkg::IDX_RUN0, 32'h3);
      pulse(0, 3);
      pulse(1, 3);
      idle(3);
      wr(cpt_pkg::IDX_RUN0, 32'h0);
      rdCount(16'h000d);
      // Snapshot of upper nibbles across a borrow
      doReset();
      setReload(16'h0100);
      wr(cpt_pkg::IDX_RUN0, 32'h3);
      rdChk(cpt_pkg::IDX_CNT0L, 32'h0);
      pulse(0, 1);
      idle(3);
      rdChk(cpt_pkg::IDX_CNT0H, 32'h0);
      rdChk(cpt_pkg::IDX_CNT1L, 32'h1);
      wr(cpt_pkg::IDX_RUN0, 32'h0);
      rdCount(16'h00ff);
      // Underflow, flag, mask, toggle
      doReset();
      setReload(16'h0001);
      wr(cpt_pkg::IDX_RUN0, 32'h3);
      rdChk(cpt_pkg::IDX_RUN0, 32'h1);
      pulse(0, 2);
      idle(4);
      rdChk(cpt_pkg::IDX_FLAG, 32'h2);
      chkBit(irqReq, 1'b0);
      chkBit(serialClk, 1'b1);
      chkBit(outPortBit2, 1'b1);
      wr(cpt_pkg::IDX_MASK, 32'h2);
      idle(2);
      chkBit(irqReq, 1'b1);
      rdChk(cpt_pkg::IDX_MASK, 32'h2);
      wr(cpt_pkg::IDX_FLAG, 32'h1);
      rdChk(cpt_pkg::IDX_FLAG, 32'h2);
      wr(cpt_pkg::IDX_FLAG, 32'h2);
      idle(2);
      rdChk(cpt_pkg::IDX_FLAG, 32'h0);
      chkBit(irqReq, 1'b0);
      wr(cpt_pkg::IDX_RUN0, 32'h0);
      idle(2);
      chkBit(serialClk, 1'b0);
      pulse(0, 3);
      idle(3);
      rdCount(16'h0001);
      wr(cpt_pkg::IDX_RUN0, 32'h1);
      wr(cpt_pkg::IDX_CLKOUT, 32'h4);
      idle(2);
      chkBit(outPortBit2, 1'b1);
      pulse(0, 2);
      idle(4);
      chkBit(outPortBit2, 1'b0);
      chkBit(serialClk, 1'b0);
      rdChk(cpt_pkg::IDX_FLAG, 32'h2);
      wr(cpt_pkg::IDX_CLKOUT, 32'h0);
      idle(2);
      chkBit(outPortBit2, 1'b1);
      // Event mode: falling, rising, then filtered edges
      doReset();
      setReload(16'h0020);
      wr(cpt_pkg::IDX_MODE, 32'hc);
      wr(cpt_pkg::IDX_RUN0, 32'hf);
      pulse(0, 4);
      repeat (3) begin
         evSet(1'b0);
         evSet(1'b1);
      end
      wr(cpt_pkg::IDX_MODE, 32'hd);
      evSet(1'b0);
      evSet(1'b1);
      wr(cpt_pkg::IDX_MODE, 32'he);
      evSet(1'b0);
      pulse(2, 1);
      evSet(1'b1);
      pulse(2, 3);
      evSet(1'b0);
      pulse(2, 3);
      evSet(1'b1);
      pulse(2, 3);
      wr(cpt_pkg::IDX_RUN0, 32'hc);
      rdCount(16'h001b);
      rdChk(cpt_pkg::IDX_MODE, 32'he);
      stop_test();
   end
endmodule
